// [rip_core.sv]
// RTC prescaler and interrupt logic with host register access
//
// Overview of operation
// - Crystal is divided to a 32 kHz rate, then to a 100 Hz tick.
// - Four crystal choices selectable; each yields the same 100 Hz tick.
// - A source interrupts only when host has written its enable bit to one.
// - Status at 00H always; bank 0 flags 03H; bank 1 routing, enables 02H-04H.
// - Status bit 0 is high while either interrupt output is active.
// - Status bits 1 to 3 are main flags set by their events.
// - Alarm match always sets its flag; output only with alarm enable.
// - Periodic enables mask the main periodic flag, not the tick flags.
// - Power fail flag set on supply loss, held until power returns.
// - All enables zero and no periodic flag pending means no interrupt output; flags still readable.
// - Status bits 2 and 3 clear by writing one; zero leaves them.
// - Any access to the tick flag register clears all tick flags.
// - Enabled compare bytes must all match; disabled bytes count as equal.
// - A compare byte with comparison off is plain host storage.
// - Six tick flags, each set by its tick regardless of enables.
// - Each rate has its own enable; any mix feeds the main periodic flag.
// - Enabled tick sets periodic flag and interrupt; writing one cancels both.
// - Periodic flag stays pending after enables clear until host clears it.
// - Each tick comes from the rollover of its time counter.
// - Power fail status follows internal signal; writes never clear it.
// - Power fail interrupt enable in upper enable register masks it.
// - Power fail is gated by chip select so accesses finish.
// - Main status holds page and bank select bits steering decode.
`timescale 1ns/1ps
`default_nettype none

module rip_core
	import rip_pkg::*;
#(
	parameter int NUM_CMP = rip_pkg::CMP_BYTES
) (
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire rip_pkg::rip_bus_t    bus,
	output logic [7:0]                dout,
	output logic                      dout_oe,
	input  wire rip_pkg::rip_xtal_t   xtal_sel,
	input  wire logic                 xtal_in,
	input  wire logic                 supply_loss_in_n,
	input  wire logic [5:0]           roll,
	input  wire logic [5:0][7:0]      cnt,
	output logic                      irq_out_n,
	output logic                      multi_function_out_n,
	output logic                      tick_100hz
);
	import rip_pkg::*;

	// Elaboration check on compare byte count
	if (NUM_CMP < 1 || NUM_CMP > CMP_BYTES) begin : g_bad
		$error("NUM_CMP out of range");
	end

	rip_st_t st_q;
	rip_st_t st_d;

	logic                 cs;
	logic                 rd_start;
	logic                 wr_done;
	logic [4:0]           a;
	logic [7:0]           wd;
	logic                 sel_ms;
	logic                 sel_tf;
	logic                 sel_rout;
	logic                 sel_enlo;
	logic                 sel_enhi;
	logic [CMP_BYTES-1:0] sel_cmp;
	logic [CMP_BYTES-1:0] eq;
	logic                 match;
	logic                 alm_int;
	logic                 pf_int;
	logic                 irq_act;
	logic                 mfo_act;
	logic                 int_stat;
	logic [7:0]           ms_val;
	logic [7:0]           rmux;
	logic                 xt_edge;
	logic [16:0]          sum;

	////////////////////////////////////////////////////////////////////////
	// Host strobes and decode

	// Second sync stage is looked at; rd and wr edge detects also use the third
	assign cs       = st_q.cs[1];
	assign rd_start = cs & st_q.rd[1] & ~st_q.rd[2];
	assign wr_done  = cs & ~st_q.wr[1] & st_q.wr[2];
	assign a        = st_q.addr[1];
	assign wd       = st_q.data[1];

	// Bank-switched decode; page 1 holds only the status register here
	assign sel_ms   = (a == ADR_MAIN);
	assign sel_tf   = ~st_q.page & ~st_q.bank & (a == ADR_TICK);
	assign sel_rout = ~st_q.page & st_q.bank & (a == ADR_ROUT);
	assign sel_enlo = ~st_q.page & st_q.bank & (a == ADR_ENLO);
	assign sel_enhi = ~st_q.page & st_q.bank & (a == ADR_ENHI);

	////////////////////////////////////////////////////////////////////////
	// Alarm compare bytes

	// Disabled or unbuilt bytes read as equal
	for (genvar i = 0; i < CMP_BYTES; i++) begin : g_cmp
		if (i < NUM_CMP) begin : g_on
			assign eq[i] = ~st_q.en_hi[i] | (st_q.cmp[i] == cnt[i]);
		end else begin : g_off
			assign eq[i] = 1'b1;
		end
		assign sel_cmp[i] = ~st_q.page & ~st_q.bank
			& (a == ADR_ALM0 + 5'(i));
	end

	// No compare enabled means no alarm, else it would fire at reset
	assign match = (&eq) & (|st_q.en_hi[CMP_BYTES-1:0]);

	////////////////////////////////////////////////////////////////////////
	// Interrupt outputs, combinational so they drop with the flag

	assign alm_int  = st_q.alm & st_q.en_hi[EH_ALM];
	assign pf_int   = st_q.pf & st_q.en_hi[EH_PF];
	// Periodic flag is not gated again: pending survives enable clear
	assign irq_act  = (alm_int & ~st_q.rout[RT_ALM])
		| (st_q.per & ~st_q.rout[RT_PER])
		| (pf_int & ~st_q.rout[RT_PF]);
	assign mfo_act  = (alm_int & st_q.rout[RT_ALM])
		| (st_q.per & st_q.rout[RT_PER])
		| (pf_int & st_q.rout[RT_PF]);
	assign int_stat = irq_act | mfo_act;

	assign irq_out_n            = ~irq_act;
	assign multi_function_out_n = ~mfo_act;

	// Status layout
	always_comb begin
		ms_val          = 8'h00;
		ms_val[MS_INT]  = int_stat;
		ms_val[MS_PF]   = st_q.pf;
		ms_val[MS_PER]  = st_q.per;
		ms_val[MS_ALM]  = st_q.alm;
		ms_val[MS_BANK] = st_q.bank;
		ms_val[MS_PAGE] = st_q.page;
	end

	// Read mux; unmapped locations read zero
	always_comb begin
		rmux = 8'h00;
		if (sel_ms)
			rmux = ms_val;
		else if (sel_tf)
			rmux = {2'b00, st_q.tf};
		else if (sel_rout)
			rmux = st_q.rout;
		else if (sel_enlo)
			rmux = st_q.en_lo;
		else if (sel_enhi)
			rmux = st_q.en_hi;
		for (int i = 0; i < CMP_BYTES; i++) begin
			if (sel_cmp[i])
				rmux = st_q.cmp[i];
		end
	end

	assign dout       = st_q.rdata;
	assign dout_oe    = cs & st_q.rd[1];
	assign tick_100hz = st_q.tick;

	////////////////////////////////////////////////////////////////////////
	// Prescaler edge and rate sum

	assign xt_edge = st_q.xt[1] & ~st_q.xt[2];
	assign sum     = {1'b0, st_q.acc} + TICK_HZ;

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_d = st_q;

		// Two-stage syncs, active high inside
		st_d.cs      = {st_q.cs[1:0], ~bus.cs_n};
		st_d.rd      = {st_q.rd[1:0], ~bus.rd_n};
		st_d.wr      = {st_q.wr[1:0], ~bus.wr_n};
		st_d.addr    = {st_q.addr[0], bus.addr};
		st_d.data    = {st_q.data[0], bus.data};
		st_d.pfl     = {st_q.pfl[0], ~supply_loss_in_n};
		st_d.xt      = {st_q.xt[1:0], xtal_in};

		// Read data frozen at strobe start, before any clear lands
		if (rd_start)
			st_d.rdata = rmux;

		// Stage one counts crystal edges, stage two accumulates rate
		st_d.tick = 1'b0;
		if (xt_edge) begin
			if (st_q.div1 >= DIV1[xtal_sel] - 8'h01) begin
				st_d.div1 = 8'h00;
				// Rate ratio kept exact by modulo sum, no drift
				if (sum >= {1'b0, MOD2[xtal_sel]}) begin
					st_d.acc  = 16'(sum - {1'b0, MOD2[xtal_sel]});
					st_d.tick = 1'b1;
				end else begin
					st_d.acc = sum[15:0];
				end
			end else begin
				st_d.div1 = st_q.div1 + 8'h01;
			end
		end

		// Power fail latched only while no access is under way
		if (!st_q.pfl[1])
			st_d.pf = 1'b0;
		else if (!cs)
			st_d.pf = 1'b1;

		// Register writes
		if (wr_done) begin
			if (sel_ms) begin
				st_d.bank = wd[MS_BANK];
				st_d.page = wd[MS_PAGE];
				if (wd[MS_PER])
					st_d.per = 1'b0;
				if (wd[MS_ALM])
					st_d.alm = 1'b0;
			end
			if (sel_rout)
				st_d.rout = wd;
			if (sel_enlo)
				st_d.en_lo = wd;
			if (sel_enhi)
				st_d.en_hi = wd;
			for (int i = 0; i < CMP_BYTES; i++) begin
				if (sel_cmp[i])
					st_d.cmp[i] = wd;
			end
		end

		// Tick flags clear on any access; a new tick wins
		if ((rd_start | wr_done) & sel_tf)
			st_d.tf = 6'h00;
		st_d.tf = st_d.tf | roll;

		// Enabled ticks set the main periodic flag; set beats clear
		if (|(roll & st_q.en_lo[TICKS-1:0]))
			st_d.per = 1'b1;

		// Alarm flag on the rising match, enable or not
		st_d.match = match;
		if (match & ~st_q.match)
			st_d.alm = 1'b1;
	end

	// One register for all state
	always_ff @(posedge clk) begin
		if (!resetn)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_tf_clear;
		rd_start & sel_tf |=> st_q.tf == $past(roll);
	endproperty
	a_tf_clear: assert property (p_tf_clear) else $error("tick flags not cleared");

	property p_per_set;
		|(roll & st_q.en_lo[5:0]) |=> st_q.per ##0 !irq_out_n || !multi_function_out_n;
	endproperty
	a_per_set: assert property (p_per_set) else $error("periodic flag missed");

	property p_per_hold;
		st_q.per & !(wr_done & sel_ms & wd[MS_PER]) |=> st_q.per;
	endproperty
	a_per_hold: assert property (p_per_hold) else $error("periodic flag lost");

	property p_alm_mask;
		!st_q.en_hi[EH_ALM] & !st_q.per & !pf_int |-> irq_out_n & multi_function_out_n;
	endproperty
	a_alm_mask: assert property (p_alm_mask) else $error("alarm drove output");

	property p_alm_set;
		match & !st_q.match |=> st_q.alm [*2];
	endproperty
	a_alm_set: assert property (p_alm_set) else $error("alarm flag missed");

	property p_alm_w0;
		st_q.alm & wr_done & sel_ms & !wd[MS_ALM] |=> st_q.alm;
	endproperty
	a_alm_w0: assert property (p_alm_w0) else $error("alarm cleared by zero");

	property p_pf_follow;
		!st_q.pfl[1] |=> !st_q.pf;
	endproperty
	a_pf_follow: assert property (p_pf_follow) else $error("power fail stuck");

	property p_pf_cs;
		$rose(st_q.pf) |-> $past(!cs);
	endproperty
	a_pf_cs: assert property (p_pf_cs) else $error("power fail during access");

	property p_pf_mask;
		!st_q.en_hi[EH_PF] & !st_q.per & !alm_int |-> irq_out_n & multi_function_out_n;
	endproperty
	a_pf_mask: assert property (p_pf_mask) else $error("power fail not masked");

	property p_int_stat;
		ms_val[MS_INT] == (!irq_out_n || !multi_function_out_n);
	endproperty
	a_int_stat: assert property (p_int_stat) else $error("status bit 0 wrong");

	property p_noen;
		st_q.en_lo == 8'h00 & st_q.en_hi[7:6] == 2'b00 & !st_q.per
			|-> irq_out_n & multi_function_out_n;
	endproperty
	a_noen: assert property (p_noen) else $error("output with no enables");

	property p_bank;
		wr_done & sel_ms |=> st_q.bank == $past(wd[MS_BANK]);
	endproperty
	a_bank: assert property (p_bank) else $error("bank select not stored");

	property p_tick;
		st_q.tick |=> !st_q.tick;
	endproperty
	a_tick: assert property (p_tick) else $error("tick longer than one cycle");

	// Tick only on the cycle after a counted crystal edge
	property p_tick_src;
		st_q.tick |-> $past(xt_edge);
	endproperty
	a_tick_src: assert property (p_tick_src) else $error("tick without crystal edge");

	// Every rollover lands in its tick flag, enabled or not
	property p_tf_set;
		|roll |=> (st_q.tf & $past(roll)) == $past(roll);
	endproperty
	a_tf_set: assert property (p_tf_set) else $error("tick flag not set");

	// Write of one clears the periodic flag unless a new tick sets it
	property p_per_clr;
		wr_done & sel_ms & wd[MS_PER] & !(|(roll & st_q.en_lo[TICKS-1:0])) |=> !st_q.per;
	endproperty
	a_per_clr: assert property (p_per_clr) else $error("periodic flag not cleared");

	// Write of one clears the alarm flag unless a new match sets it
	property p_alm_clr;
		wr_done & sel_ms & wd[MS_ALM] & !(match & !st_q.match) |=> !st_q.alm;
	endproperty
	a_alm_clr: assert property (p_alm_clr) else $error("alarm flag not cleared");

	// Supply loss with the bus idle raises the power fail flag
	property p_pf_set;
		st_q.pfl[1] & !cs |=> st_q.pf;
	endproperty
	a_pf_set: assert property (p_pf_set) else $error("power fail flag missed");

	// Nothing but supply return drops a raised power fail flag
	property p_pf_wr;
		st_q.pf & st_q.pfl[1] |=> st_q.pf;
	endproperty
	a_pf_wr: assert property (p_pf_wr) else $error("power fail flag cleared early");

	// Upper enable writes land as written
	property p_en_store;
		wr_done & sel_enhi |=> st_q.en_hi == $past(wd);
	endproperty
	a_en_store: assert property (p_en_store) else $error("enable byte not stored");

	// A pending periodic flag drives the output its routing bit picks
	property p_route_per;
		st_q.per |-> (st_q.rout[RT_PER] ? !multi_function_out_n : !irq_out_n);
	endproperty
	a_route_per: assert property (p_route_per) else $error("periodic output misrouted");

endmodule

`default_nettype wire

// [rip_host.sv]
// Host processor model driving the byte-wide register bus
`timescale 1ns/1ps
`default_nettype none

module rip_host
	import rip_pkg::*;
(
	input  wire logic       clk,
	input  wire logic [7:0] dout,
	output var  rip_pkg::rip_bus_t bus
);
	import rip_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Idle bus at time zero; pins change only at falling edges
	initial begin
		bus = '{1'b1, 1'b1, 1'b1, 5'h00, 8'h00};
	end

	// Wait a number of falling edges
	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Write: strobe 4 clocks, select and address held 4 clocks past it
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge clk);
		bus = '{1'b0, 1'b1, 1'b0, a, d};
		hold(4);
		bus.wr_n = 1'b1;
		hold(4);
		// Released data inverted so a stale byte never looks valid
		bus = '{1'b1, 1'b1, 1'b1, a, ~d};
		hold(3);
	endtask

	// Read: data taken while strobe still low, well past the answer
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(negedge clk);
		bus = '{1'b0, 1'b0, 1'b1, a, ~bus.data};
		hold(5);
		d = dout;
		bus.rd_n = 1'b1;
		hold(4);
		bus.cs_n = 1'b1;
		hold(3);
	endtask
endmodule

`default_nettype wire

// [rip_pkg.sv]
// Constants, carriers and state layout of the RTC interrupt and prescaler block
package rip_pkg;

	// Register offsets on the host address bus
	localparam logic [4:0] ADR_MAIN = 5'h00;
	localparam logic [4:0] ADR_ROUT = 5'h02;
	localparam logic [4:0] ADR_TICK = 5'h03;
	localparam logic [4:0] ADR_ENLO = 5'h03;
	localparam logic [4:0] ADR_ENHI = 5'h04;
	localparam logic [4:0] ADR_ALM0 = 5'h13;

	// Main status bit positions
	localparam int MS_INT  = 0;
	localparam int MS_PF   = 1;
	localparam int MS_PER  = 2;
	localparam int MS_ALM  = 3;
	localparam int MS_BANK = 6;
	localparam int MS_PAGE = 7;

	// Upper enable register bits; low bits enable compare bytes
	localparam int EH_PF  = 6;
	localparam int EH_ALM = 7;

	// Routing bits: one steers the source to the second output
	localparam int RT_PF  = 0;
	localparam int RT_PER = 1;
	localparam int RT_ALM = 2;

	localparam int CMP_BYTES = 6;
	localparam int TICKS     = 6;

	// Prescaler: first stage divide per crystal, then a rate accumulator
	localparam logic [7:0]  DIV1 [4] = '{8'h01, 8'h01, 8'h96, 8'h80};
	localparam logic [15:0] MOD2 [4] = '{16'h7d00, 16'h8000, 16'h8000, 16'h8000};
	localparam logic [16:0] TICK_HZ = 17'h00064;

	// Crystal choices
	typedef enum logic [1:0] {
		XT_32K   = 2'b00,
		XT_32K7  = 2'b01,
		XT_4M91  = 2'b10,
		XT_4M19  = 2'b11
	} rip_xtal_t;

	// Host bus pins as seen at the device
	typedef struct packed {
		logic       cs_n;
		logic       rd_n;
		logic       wr_n;
		logic [4:0] addr;
		logic [7:0] data;
	} rip_bus_t;

	// Whole block state
	typedef struct packed {
		logic [2:0]       cs;
		logic [2:0]       rd;
		logic [2:0]       wr;
		logic [1:0][4:0]  addr;
		logic [1:0][7:0]  data;
		logic [1:0]       pfl;
		logic [2:0]       xt;
		logic             pf;
		logic [TICKS-1:0] tf;
		logic             per;
		logic             alm;
		logic             match;
		logic             bank;
		logic             page;
		logic [7:0]       rout;
		logic [7:0]       en_lo;
		logic [7:0]       en_hi;
		logic [CMP_BYTES-1:0][7:0] cmp;
		logic [7:0]       rdata;
		logic [7:0]       div1;
		logic [15:0]      acc;
		logic             tick;
	} rip_st_t;

endpackage

// [tb_rtc_interrupt_and_prescaler.sv]
// Self-checking bench for the RTC interrupt and prescaler block
`timescale 1ns/1ps
`default_nettype none

module tb_rtc_interrupt_and_prescaler;
	import rip_pkg::*;

	typedef struct packed {
		logic [4:0] a;
		logic [7:0] w;
		logic [7:0] e;
	} rip_row_t;

	logic            clk = 1'b0;
	logic            resetn = 1'b0;
	rip_bus_t        bus;
	logic [7:0]      dout;
	logic            dout_oe;
	rip_xtal_t       xtal_sel = XT_32K;
	logic            xtal_in = 1'b0;
	logic            loss_n = 1'b1;
	logic [5:0]      roll = 6'h00;
	logic [5:0][7:0] cnt = 48'h0;
	logic            irq_n;
	logic            mfo_n;
	logic            tick;
	int              failures = 0;
	int              n_checks = 0;
	int              cyc = 0;
	int              gap;
	// Write then read back; last row is an unmapped place
	rip_row_t        rows [5] = '{
		'{5'h00, 8'h40, 8'h40},
		'{5'h03, 8'h2a, 8'h2a},
		'{5'h04, 8'hc0, 8'hc0},
		'{5'h02, 8'h05, 8'h05},
		'{5'h1f, 8'hff, 8'h00}};

	////////////////////////////////////////////////////////////////////////////////
	rip_core dut_u (
		.clk                  (clk),
		.resetn               (resetn),
		.bus                  (bus),
		.dout                 (dout),
		.dout_oe              (dout_oe),
		.xtal_sel             (xtal_sel),
		.xtal_in              (xtal_in),
		.supply_loss_in_n     (loss_n),
		.roll                 (roll),
		.cnt                  (cnt),
		.irq_out_n            (irq_n),
		.multi_function_out_n (mfo_n),
		.tick_100hz           (tick)
	);
	rip_host h (
		.clk  (clk),
		.dout (dout),
		.bus  (bus)
	);

	// Clock, and a crystal stand-in with one rising edge every 4 clocks
	always #5 clk = ~clk;
	always begin
		repeat (2) @(negedge clk);
		xtal_in = ~xtal_in;
	end

	// Hang guard well above the expected run length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			failures++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic rdc(input string nm, input logic [4:0] a, input logic [7:0] e);
		logic [7:0] d;
		h.rd(a, d);
		chk(nm, 16'(d), 16'(e));
	endtask

	// One-cycle rollover pulse; flags land on the edge inside it
	task automatic pr(input int i);
		@(negedge clk);
		roll[i] = 1'b1;
		@(negedge clk);
		roll = 6'h00;
	endtask

	// Clocks between two tick pulses
	task automatic tgap(output int n);
		@(posedge tick);
		@(negedge clk);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tick !== 1'b1);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(negedge clk);
		chk("irq reset", 16'(irq_n), 16'h1);
		chk("mfo reset", 16'(mfo_n), 16'h1);
		chk("oe reset", 16'(dout_oe), 16'h0);
		resetn = 1'b1;
		$display("reset test done");
		// Register map in bank 1
		foreach (rows[i]) begin
			h.wr(rows[i].a, rows[i].w);
			rdc("regmap", rows[i].a, rows[i].e);
		end
		$display("table test done");
		// Periodic path, routed to the main output
		h.wr(5'h04, 8'h00);
		h.wr(5'h02, 8'h00);
		h.wr(5'h03, 8'h01);
		pr(1);
		chk("irq masked rate", 16'(irq_n), 16'h1);
		pr(0);
		chk("irq periodic", 16'(irq_n), 16'h0);
		rdc("status per", 5'h00, 8'h45);
		h.wr(5'h00, 8'h40);
		chk("irq write zero", 16'(irq_n), 16'h0);
		h.wr(5'h03, 8'h00);
		chk("irq pending", 16'(irq_n), 16'h0);
		h.wr(5'h00, 8'h44);
		chk("irq cleared", 16'(irq_n), 16'h1);
		rdc("status clr", 5'h00, 8'h40);
		// Data pins driven only inside a read
		fork
			rdc("status oe", 5'h00, 8'h40);
			begin
				repeat (4) @(negedge clk);
				chk("oe read", 16'(dout_oe), 16'h1);
			end
		join
		chk("oe idle", 16'(dout_oe), 16'h0);
		// Tick flags in bank 0: set regardless, cleared by any access
		h.wr(5'h00, 8'h00);
		rdc("tick flags", 5'h03, 8'h03);
		rdc("tick cleared", 5'h03, 8'h00);
		pr(5);
		h.wr(5'h03, 8'h00);
		rdc("tick wr clr", 5'h03, 8'h00);
		$display("periodic test done");
		// Compare byte as storage while comparison is off
		h.wr(5'h13, 8'h55);
		rdc("cmp store", 5'h13, 8'h55);
		cnt[1] = 8'h07;
		h.wr(5'h00, 8'h40);
		h.wr(5'h02, 8'h04);
		h.wr(5'h04, 8'h03);
		cnt[0] = 8'h55;
		repeat (3) @(negedge clk);
		rdc("one byte off", 5'h00, 8'h40);
		cnt[1] = 8'h00;
		repeat (3) @(negedge clk);
		chk("mfo alarm off", 16'(mfo_n), 16'h1);
		rdc("alarm flag", 5'h00, 8'h48);
		h.wr(5'h04, 8'h83);
		chk("mfo alarm", 16'(mfo_n), 16'h0);
		chk("irq alarm", 16'(irq_n), 16'h1);
		h.wr(5'h00, 8'h48);
		chk("mfo alarm clr", 16'(mfo_n), 16'h1);
		$display("alarm test done");
		// Supply loss on the main output
		h.wr(5'h02, 8'h00);
		h.wr(5'h04, 8'h40);
		loss_n = 1'b0;
		repeat (6) @(negedge clk);
		chk("irq supply_loss_in", 16'(irq_n), 16'h0);
		h.wr(5'h00, 8'h42);
		chk("supply_loss_in no clr", 16'(irq_n), 16'h0);
		h.wr(5'h04, 8'h00);
		chk("supply_loss_in masked", 16'(irq_n), 16'h1);
		h.wr(5'h04, 8'h40);
		chk("supply_loss_in unmask", 16'(irq_n), 16'h0);
		loss_n = 1'b1;
		repeat (6) @(negedge clk);
		chk("supply_loss_in gone", 16'(irq_n), 16'h1);
		$display("power fail test done");
		// Mid-run reset with a periodic interrupt pending
		h.wr(5'h03, 8'h01);
		pr(0);
		chk("irq before reset", 16'(irq_n), 16'h0);
		resetn = 1'b0;
		repeat (4) @(negedge clk);
		chk("irq in reset", 16'(irq_n), 16'h1);
		resetn = 1'b1;
		rdc("status reset", 5'h00, 8'h00);
		$display("mid reset test done");
		// Prescaler spacing, second gap of each setting
		tgap(gap);
		tgap(gap);
		chk("gap 32k", 16'(gap), 16'h0500);
		xtal_sel = XT_32K7;
		tgap(gap);
		tgap(gap);
		chk("gap 32k7", 16'(gap == 1308 || gap == 1312), 16'h1);
		$display("prescaler test done");
		test_done();
	end
endmodule

`default_nettype wire
